/* design/gate_dead_time_cell.sv */
/*
 * One inverter leg: turns a phase demand into complementary upper and
 * lower gate drives with a programmable dead gap and selectable polarity.
 * Assumes inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module gate_dead_time_cell
    import svm_pwm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic enable,
    input wire logic demand,
    input wire logic [DEAD_W-1:0] dead_time_count,
    input wire logic upper_pol,
    input wire logic lower_pol,
    output logic gate_upper_q,
    output logic gate_lower_q
);

    logic side_q;
    logic [DEAD_W-1:0] gap_q;
    logic changed;
    logic on_upper;
    logic on_lower;

    assign changed = demand != side_q;
    // Both switches stay off while the gap counts down
    assign on_upper = enable && !changed && gap_q == '0 && side_q;
    assign on_lower = enable && !changed && gap_q == '0 && !side_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            side_q <= 1'b0;
            gap_q <= '0;
        end
        else if (changed)
        begin
            side_q <= demand;
            gap_q <= (dead_time_count == '0) ? '0 : dead_time_count - 1'b1;
        end
        else if (gap_q != '0)
        begin
            gap_q <= gap_q - 1'b1;
        end
    end

    // Reset shows the inactive level of the default active-low sense
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            gate_upper_q <= 1'b1;
            gate_lower_q <= 1'b1;
        end
        else
        begin
            gate_upper_q <= upper_pol ? on_upper : !on_upper;
            gate_lower_q <= lower_pol ? on_lower : !on_lower;
        end
    end

endmodule : gate_dead_time_cell

`default_nettype wire

/* design/svm_pwm_ctrl.sv */
/*
 * Write-register configuration and run control of a three-phase
 * space-vector PWM generator: host parallel port, carrier, modulation
 * modes, guard band, dead time, polarities, fault, current scaling.
 * Assumes duty references and current samples come from the same clock;
 * host port pins and the kill pin are asynchronous and are synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// - shutdown output follows shutdown control bit
// - brake output polarity set by bit
// - sync pulse polarity set by bit
// - upper gate polarity set by bit
// - lower gate polarity set by bit
// - kill input sense set by bit
// - carrier period is two times (value+1)
// - alignment bit picks asymmetric or symmetric
// - modulation bit picks three or two phase
// - variant picks two-phase type, two-phase only
// - dead gap equals programmed clock count, one clock when count is zero
// - keep edges out of sampling guard band
// - guard band only in three-phase mode
// - scale rotating currents by signed Q10 factor
// - leg shunt: wait delay before offset remeasure
// - add V offset when compensation bit low
// - direction bit picks reverse or forward
// - run bit starts or stops motor
// - coast stop bit stops motor immediately
// - all registers in one 128-byte space
// - fault disables gate outputs and raises fault
module svm_pwm_ctrl
    import svm_pwm_pkg::*;
#(
    parameter int SEC_CYCLES = ONE_SEC_CYCLES,
    parameter int PHASES = 3
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [DATA_W-1:0] hp_data,
    input wire logic hp_a,
    input wire logic hp_wr_n,
    input wire logic gate_kill_in,
    input wire logic [PHASES*REF_W-1:0] duty_ref,
    input wire logic brake_request,
    input wire logic leg_shunt_select,
    input wire logic offset_comp_control,
    input wire logic signed [VOFS_W-1:0] v_phase_offset,
    input wire logic signed [VOFS_W-1:0] iv_meas,
    input wire logic signed [SCALE_W-1:0] id_meas,
    input wire logic signed [SCALE_W-1:0] iq_meas,
    output logic [PHASES-1:0] gate_upper,
    output logic [PHASES-1:0] gate_lower,
    output logic gate_driver_shutdown_q,
    output logic brake_out_q,
    output logic pwm_sync_q,
    output logic fault_q,
    output logic run_active_q,
    output logic direction_q,
    output logic offset_measure_start_q,
    output logic signed [VOFS_W:0] iv_corrected_q,
    output logic signed [SCALE_W-1:0] id_scaled_q,
    output logic signed [SCALE_W-1:0] iq_scaled_q
);

    localparam int CMP_W = PERIOD_W + 1;
    localparam int PROD_W = REF_W + SCALE_W;
    localparam int IPROD_W = SCALE_W + IFB_SCALE_W;
    localparam int SEC_W = $clog2(SEC_CYCLES + 1);

    // Host port pins pass two flip-flops before use
    logic [DATA_W-1:0] data_s1_q, data_s2_q;
    logic a_s1_q, a_s2_q, wr_s1_q, wr_s2_q, wr_s3_q;
    logic kill_s1_q, kill_s2_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            data_s1_q <= '0;
            data_s2_q <= '0;
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            wr_s1_q <= 1'b1;
            wr_s2_q <= 1'b1;
            wr_s3_q <= 1'b1;
            // Rest at the pin's idle level, else reset latches a false kill
            kill_s1_q <= 1'b1;
            kill_s2_q <= 1'b1;
        end
        else
        begin
            data_s1_q <= hp_data;
            data_s2_q <= data_s1_q;
            a_s1_q <= hp_a;
            a_s2_q <= a_s1_q;
            wr_s1_q <= hp_wr_n;
            wr_s2_q <= wr_s1_q;
            wr_s3_q <= wr_s2_q;
            kill_s1_q <= gate_kill_in;
            kill_s2_q <= kill_s1_q;
        end
    end

    // A byte is taken at the trailing edge of the write strobe
    logic wr_done, addr_wr, data_wr;
    logic [ADDR_W-1:0] addr_q;
    assign wr_done = wr_s2_q && !wr_s3_q;
    assign addr_wr = wr_done && a_s2_q;
    assign data_wr = wr_done && !a_s2_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            addr_q <= '0;
        else if (addr_wr)
            addr_q <= data_s2_q[ADDR_W-1:0];
        else if (data_wr)
            addr_q <= addr_q + 1'b1;
    end

    logic wr_pol, wr_plo, wr_mode, wr_dead, wr_islo, wr_ishi;
    logic wr_cmd, wr_mslo, wr_mshi, wr_guard, wr_remeas;
    assign wr_pol = data_wr && addr_q == OFS_POLARITY;
    assign wr_plo = data_wr && addr_q == OFS_PERIOD_LO;
    assign wr_mode = data_wr && addr_q == OFS_MODE_PERIOD_HI;
    assign wr_dead = data_wr && addr_q == OFS_DEAD_TIME;
    assign wr_islo = data_wr && addr_q == OFS_IFB_SCALE_LO;
    assign wr_ishi = data_wr && addr_q == OFS_IFB_SCALE_HI;
    assign wr_cmd = data_wr && addr_q == OFS_MOTOR_CMD;
    assign wr_mslo = data_wr && addr_q == OFS_MOD_SCALE_LO;
    assign wr_mshi = data_wr && addr_q == OFS_MOD_SCALE_HI;
    assign wr_guard = data_wr && addr_q == OFS_GUARD_BAND;
    assign wr_remeas = data_wr && addr_q == OFS_REMEASURE;

    polarity_cfg_t pol_q;
    mode_cfg_t mode_q;
    motor_cmd_t cmd_q;
    logic [DEAD_W-1:0] dead_q;
    logic [DATA_W-1:0] guard_q, remeas_q;
    logic [SCALE_W-1:0] mod_scale_q;
    logic [IFB_SCALE_W-1:0] ifb_scale_q;
    logic [DATA_W-1:0] d;
    assign d = data_s2_q;

    // Only documented fields are stored; spare bits fall away
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pol_q <= '0;
            mode_q <= '0;
            cmd_q <= '0;
            dead_q <= '0;
            guard_q <= '0;
            remeas_q <= '0;
            mod_scale_q <= '0;
            ifb_scale_q <= '0;
        end
        else
        begin
            if (wr_pol)
                pol_q <= {d[BIT_KILL_POL], d[BIT_LOWER_POL], d[BIT_UPPER_POL],
                    d[BIT_SYNC_POL], d[BIT_BRAKE_POL], d[BIT_SHUTDOWN]};
            if (wr_plo)
                mode_q.carrier_period[DATA_W-1:0] <= d;
            if (wr_mode)
            begin
                mode_q.carrier_period[PERIOD_W-1:DATA_W] <= d[PERIOD_HI_W-1:0];
                mode_q.alignment_select <= d[BIT_ALIGN];
                mode_q.two_phase_variant <= d[BIT_VARIANT];
                mode_q.modulation_select <= d[BIT_MOD_SEL];
            end
            if (wr_cmd)
                cmd_q <= {d[BIT_COAST], d[BIT_RUN], d[BIT_DIRECTION]};
            if (wr_dead)
                dead_q <= d;
            if (wr_guard)
                guard_q <= d;
            if (wr_remeas)
                remeas_q <= d;
            if (wr_mslo)
                mod_scale_q[DATA_W-1:0] <= d;
            if (wr_mshi)
                mod_scale_q[SCALE_W-1:DATA_W] <= d;
            if (wr_islo)
                ifb_scale_q[DATA_W-1:0] <= d;
            if (wr_ishi)
                ifb_scale_q[IFB_SCALE_W-1:DATA_W] <= d[IFB_SCALE_W-DATA_W-1:0];
        end
    end

    // Up-down carrier: 0..P then P..0, so 2*(P+1) clocks a period
    logic [PERIOD_W-1:0] cnt_q;
    logic down_q;
    logic at_top, at_bottom, at_update;
    assign at_top = !down_q && cnt_q == mode_q.carrier_period;
    assign at_bottom = down_q && cnt_q == '0;
    // Symmetric reloads once a period, asymmetric at both ends
    assign at_update = at_bottom || (at_top && !mode_q.alignment_select);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            down_q <= 1'b0;
        end
        else if (at_top)
            down_q <= 1'b1;
        else if (at_bottom)
            down_q <= 1'b0;
        else if (down_q)
            cnt_q <= cnt_q - 1'b1;
        else
            cnt_q <= cnt_q + 1'b1;
    end

    // Guard band in clock cycles, rounded up
    logic [CMP_W-1:0] guard_cycles;
    assign guard_cycles = CMP_W'((32'(guard_q) * GUARD_STEP_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS);

    logic [CMP_W-1:0] raw_cmp [PHASES];
    logic [CMP_W-1:0] min_cmp, max_cmp, shift_up;
    logic [CMP_W-1:0] cmp_d [PHASES];
    logic [CMP_W-1:0] cmp_q [PHASES];

    genvar p;
    generate
        for (p = 0; p < PHASES; p++)
        begin : g_scale
            logic [PROD_W-1:0] prod;
            logic [PROD_W-1:0] lim;
            assign prod = duty_ref[p*REF_W +: REF_W] * mod_scale_q;
            assign lim = prod >> MOD_SHIFT;
            assign raw_cmp[p] = (lim > PROD_W'(mode_q.carrier_period))
                ? CMP_W'(mode_q.carrier_period) + 1'b1 : lim[CMP_W-1:0];
        end
    endgenerate

    always_comb
    begin
        min_cmp = raw_cmp[0];
        max_cmp = raw_cmp[0];
        for (int i = 1; i < PHASES; i++)
        begin
            if (raw_cmp[i] < min_cmp)
                min_cmp = raw_cmp[i];
            if (raw_cmp[i] > max_cmp)
                max_cmp = raw_cmp[i];
        end
    end
    assign shift_up = CMP_W'(mode_q.carrier_period) + 1'b1 - max_cmp;

    generate
        for (p = 0; p < PHASES; p++)
        begin : g_mode
            logic [CMP_W-1:0] clamped;
            assign clamped = (raw_cmp[p] != '0 && raw_cmp[p] < guard_cycles)
                ? guard_cycles : raw_cmp[p];
            // Two-phase: type 1 pins the lowest leg off, type 2 the highest on
            assign cmp_d[p] = !mode_q.modulation_select ? clamped
                : mode_q.two_phase_variant ? raw_cmp[p] + shift_up
                : raw_cmp[p] - min_cmp;
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    cmp_q[p] <= '0;
                else if (at_update)
                    cmp_q[p] <= cmp_d[p];
            end
        end
    endgenerate

    // Kill sense, fault latch and run state
    logic kill_active, fault_d, run_d;
    assign kill_active = !(kill_s2_q ^ pol_q.kill_input_polarity);
    // A kill in the clearing cycle keeps the fault set
    assign fault_d = kill_active || (fault_q && !(wr_cmd && !d[BIT_RUN]));
    assign run_d = cmd_q.run_request && !cmd_q.coast_stop_request && !fault_d;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fault_q <= 1'b0;
            run_active_q <= 1'b0;
            direction_q <= 1'b0;
        end
        else
        begin
            fault_q <= fault_d;
            run_active_q <= run_d;
            direction_q <= cmd_q.direction;
        end
    end

    // Reverse rotation swaps the second and third legs
    logic [PHASES-1:0] demand;
    generate
        for (p = 0; p < PHASES; p++)
        begin : g_leg
            localparam int SRC = (p == 0) ? 0 : PHASES - p;
            logic [CMP_W-1:0] sel_cmp;
            assign sel_cmp = cmd_q.direction ? cmp_q[p] : cmp_q[SRC];
            assign demand[p] = CMP_W'(cnt_q) < sel_cmp;
            gate_dead_time_cell u_cell (
                .mclk(mclk),
                .rst(rst),
                .enable(run_active_q && !fault_q),
                .demand(demand[p]),
                .dead_time_count(dead_q),
                .upper_pol(pol_q.upper_gate_polarity),
                .lower_pol(pol_q.lower_gate_polarity),
                .gate_upper_q(gate_upper[p]),
                .gate_lower_q(gate_lower[p])
            );
        end
    endgenerate

    // Sync pulse at the sampling instant, brake and shutdown lines
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pwm_sync_q <= 1'b1;
            brake_out_q <= 1'b1;
            gate_driver_shutdown_q <= 1'b0;
        end
        else
        begin
            pwm_sync_q <= pol_q.sync_out_polarity ? at_bottom : !at_bottom;
            brake_out_q <= pol_q.brake_polarity ? brake_request : !brake_request;
            gate_driver_shutdown_q <= pol_q.gate_driver_shutdown;
        end
    end

    // Offset remeasure delay after a stop, counted in whole seconds
    logic [SEC_W-1:0] sec_q;
    logic [DATA_W-1:0] secs_left_q;
    logic waiting_q, run_was_q, stop_seen, sec_tick;
    assign stop_seen = run_was_q && !cmd_q.run_request;
    assign sec_tick = sec_q == SEC_W'(SEC_CYCLES - 1);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            run_was_q <= 1'b0;
            waiting_q <= 1'b0;
            sec_q <= '0;
            secs_left_q <= '0;
            offset_measure_start_q <= 1'b0;
        end
        else
        begin
            run_was_q <= cmd_q.run_request;
            offset_measure_start_q <= 1'b0;
            if (stop_seen && leg_shunt_select)
            begin
                waiting_q <= 1'b1;
                sec_q <= '0;
                secs_left_q <= remeas_q;
            end
            else if (waiting_q)
            begin
                sec_q <= sec_tick ? '0 : sec_q + 1'b1;
                if (secs_left_q == '0)
                begin
                    waiting_q <= 1'b0;
                    offset_measure_start_q <= 1'b1;
                end
                else if (sec_tick)
                    secs_left_q <= secs_left_q - 1'b1;
            end
        end
    end

    // Current feedback: V offset and rotating-frame scaling
    logic signed [IPROD_W-1:0] id_prod, iq_prod;
    assign id_prod = id_meas * $signed(ifb_scale_q);
    assign iq_prod = iq_meas * $signed(ifb_scale_q);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            iv_corrected_q <= '0;
            id_scaled_q <= '0;
            iq_scaled_q <= '0;
        end
        else
        begin
            iv_corrected_q <= offset_comp_control ? (VOFS_W+1)'(iv_meas)
                : (VOFS_W+1)'(iv_meas) + (VOFS_W+1)'(v_phase_offset);
            id_scaled_q <= id_prod[IFB_FRAC +: SCALE_W];
            iq_scaled_q <= iq_prod[IFB_FRAC +: SCALE_W];
        end
    end

endmodule : svm_pwm_ctrl

`default_nettype wire

/* design/svm_pwm_pkg.sv */
/*
 * Shared constants and types for the space-vector PWM configuration and
 * run-control block: register offsets, field positions, timing figures.
 * Assumes a single 40 MHz system clock and an 8-bit host parallel port.
 */
package svm_pwm_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int GUARD_STEP_NS = 30;
    localparam int REMEASURE_STEP_S = 1;
    localparam int ONE_SEC_CYCLES = REMEASURE_STEP_S * CLK_HZ;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int PERIOD_W = 12;
    localparam int DEAD_W = 8;
    localparam int SCALE_W = 16;
    localparam int IFB_SCALE_W = 15;
    localparam int IFB_FRAC = 10;
    localparam int VOFS_W = 12;
    localparam int REF_W = 12;
    localparam int MOD_SHIFT = 14;

    localparam logic [ADDR_W-1:0] OFS_POLARITY = 7'h0c;
    localparam logic [ADDR_W-1:0] OFS_PERIOD_LO = 7'h0d;
    localparam logic [ADDR_W-1:0] OFS_MODE_PERIOD_HI = 7'h0e;
    localparam logic [ADDR_W-1:0] OFS_DEAD_TIME = 7'h0f;
    localparam logic [ADDR_W-1:0] OFS_IFB_SCALE_LO = 7'h15;
    localparam logic [ADDR_W-1:0] OFS_IFB_SCALE_HI = 7'h16;
    localparam logic [ADDR_W-1:0] OFS_MOTOR_CMD = 7'h17;
    localparam logic [ADDR_W-1:0] OFS_MOD_SCALE_LO = 7'h44;
    localparam logic [ADDR_W-1:0] OFS_MOD_SCALE_HI = 7'h45;
    localparam logic [ADDR_W-1:0] OFS_GUARD_BAND = 7'h51;
    localparam logic [ADDR_W-1:0] OFS_REMEASURE = 7'h7d;

    // Output polarity and control byte
    localparam int BIT_SHUTDOWN = 1;
    localparam int BIT_BRAKE_POL = 2;
    localparam int BIT_SYNC_POL = 3;
    localparam int BIT_UPPER_POL = 4;
    localparam int BIT_LOWER_POL = 5;
    localparam int BIT_KILL_POL = 7;
    // Mode byte
    localparam int BIT_ALIGN = 4;
    localparam int BIT_VARIANT = 6;
    localparam int BIT_MOD_SEL = 7;
    localparam int PERIOD_HI_W = 4;
    // Command byte
    localparam int BIT_DIRECTION = 0;
    localparam int BIT_RUN = 1;
    localparam int BIT_COAST = 2;

    typedef struct packed {
        logic kill_input_polarity;
        logic lower_gate_polarity;
        logic upper_gate_polarity;
        logic sync_out_polarity;
        logic brake_polarity;
        logic gate_driver_shutdown;
    } polarity_cfg_t;

    typedef struct packed {
        logic modulation_select;
        logic two_phase_variant;
        logic alignment_select;
        logic [PERIOD_W-1:0] carrier_period;
    } mode_cfg_t;

    typedef struct packed {
        logic coast_stop_request;
        logic run_request;
        logic direction;
    } motor_cmd_t;

endpackage : svm_pwm_pkg

/* verif/gate_driver_model.sv */
/*
 * Gate driver model: decodes gate sense, times the dead gap on leg 0,
 * flags both switches of a leg on, drives the kill pin (pulled up).
 */
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model
(
    input wire logic mclk,
    input wire logic [2:0] gate_upper,
    input wire logic [2:0] gate_lower,
    input wire logic gate_pol,
    input wire logic trip,
    output logic kill_n,
    output logic both_on,
    output logic [7:0] gap_q
);
    logic [7:0] off_q = 8'h00;
    wire logic [2:0] up_on = gate_upper ~^ {3{gate_pol}};
    wire logic [2:0] lo_on = gate_lower ~^ {3{gate_pol}};
    // Fault line is open drain, so idle reads high
    assign kill_n = !trip;
    assign both_on = |(up_on & lo_on);
    initial gap_q = 8'h00;
    always @(posedge mclk)
    begin
        if (up_on[0] | lo_on[0])
        begin
            if (off_q != 8'h00)
                gap_q <= off_q;
            off_q <= 8'h00;
        end
        else
            off_q <= off_q + 8'h01;
    end
endmodule : gate_driver_model
`default_nettype wire

/* verif/svm_pwm_ctrl_asserts.sv */
/*
 * Port checker for svm_pwm_ctrl: write-driven outputs, fault, brake, offset sum.
 * Assumes the single mclk domain and the async high reset of the block.
 */
`timescale 1ns/1ps
`default_nettype none
module svm_pwm_ctrl_asserts
    import svm_pwm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic hp_wr_n,
    input wire logic gate_kill_in,
    input wire logic brake_request,
    input wire logic offset_comp_control,
    input wire logic signed [VOFS_W-1:0] v_phase_offset,
    input wire logic signed [VOFS_W-1:0] iv_meas,
    input wire logic gate_driver_shutdown_q,
    input wire logic brake_out_q,
    input wire logic fault_q,
    input wire logic run_active_q,
    input wire logic direction_q,
    input wire logic offset_measure_start_q,
    input wire logic signed [VOFS_W:0] iv_corrected_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic wr_prev_q;
    logic [3:0] quiet_q;
    // Host port idle long enough that no write can still be landing
    wire logic calm = quiet_q > 4'h9;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wr_prev_q <= 1'h1;
            quiet_q <= 4'h0;
        end
        else
        begin
            wr_prev_q <= hp_wr_n;
            quiet_q <= (hp_wr_n != wr_prev_q) ? 4'h0 : quiet_q + {3'h0, ~&quiet_q};
        end
    end
    sequence s_kill_quiet;
        (calm && $stable(gate_kill_in)) [*4];
    endsequence
    property p_shutdown;
        $changed(gate_driver_shutdown_q) |-> !calm;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown moved without write");
    property p_brake;
        calm && $changed(brake_request) |=> $changed(brake_out_q);
    endproperty
    a_brake: assert property (p_brake) else $error("brake output did not follow");
    property p_kill;
        s_kill_quiet |-> !$rose(fault_q);
    endproperty
    a_kill: assert property (p_kill) else $error("fault rose with quiet kill pin");
    property p_run;
        $rose(run_active_q) |-> !calm;
    endproperty
    a_run: assert property (p_run) else $error("run started without write");
    property p_direction;
        $changed(direction_q) |-> !calm;
    endproperty
    a_direction: assert property (p_direction) else $error("direction moved alone");
    property p_fault;
        fault_q [*2] |-> !run_active_q;
    endproperty
    a_fault: assert property (p_fault) else $error("running during fault");
    property p_offset;
        !$past(rst) && !$past(offset_comp_control)
            |-> iv_corrected_q == $past(iv_meas) + $past(v_phase_offset);
    endproperty
    a_offset: assert property (p_offset) else $error("offset sum wrong");
    property p_remeasure;
        offset_measure_start_q |=> !offset_measure_start_q;
    endproperty
    a_remeasure: assert property (p_remeasure) else $error("remeasure pulse too long");
endmodule : svm_pwm_ctrl_asserts
bind svm_pwm_ctrl svm_pwm_ctrl_asserts chk_i (.*);
`default_nettype wire

/* verif/svm_pwm_ctrl_tb_top.sv */
/*
 * Self-checking bench for svm_pwm_ctrl with a gate driver model.
 * Host port driven at falling edges; remeasure second shortened to 20 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module svm_pwm_ctrl_tb_top
    import svm_pwm_pkg::*;
;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] hp_data = 8'h00;
    logic hp_a = 1'h0;
    logic hp_wr_n = 1'h1;
    logic trip = 1'h0;
    logic gate_pol = 1'h0;
    logic [35:0] duty_ref = {3{12'h800}};
    logic brake_request = 1'h0;
    logic leg_shunt_select = 1'h0;
    logic offset_comp_control = 1'h0;
    logic signed [11:0] v_phase_offset = 12'h007;
    logic signed [11:0] iv_meas = 12'hffb;
    logic signed [15:0] id_meas = 16'h0123;
    logic signed [15:0] iq_meas = 16'hfff0;
    logic [2:0] gate_upper, gate_lower;
    logic gate_kill_in, gate_driver_shutdown_q, brake_out_q, pwm_sync_q, fault_q;
    logic run_active_q, direction_q, offset_measure_start_q, both_on;
    logic signed [12:0] iv_corrected_q;
    logic signed [15:0] id_scaled_q, iq_scaled_q;
    logic [7:0] gap;
    logic s = 1'h0;
    int err_count = 0;
    int checks_done = 0;
    int n, c;
    // Polarity byte, then {shutdown, brake idle, upper[0], lower[0]}
    localparam logic [11:0] ROWS [6] = '{12'h007, 12'h02f, 12'h043, 12'h304, 12'h417,
        12'h3e8};
    // Mode byte, guard band, upper-on cycles per carrier
    localparam logic [23:0] MODES [5] = '{24'h00_0003, 24'h10_0003, 24'h10_0407,
        24'h90_0400, 24'hd0_0414};
    svm_pwm_ctrl #(.SEC_CYCLES(20)) uut (.*);
    gate_driver_model drv (.mclk(mclk), .gate_upper(gate_upper), .gate_lower(gate_lower),
        .gate_pol(gate_pol), .trip(trip), .kill_n(gate_kill_in), .both_on(both_on),
        .gap_q(gap));
    always #12.5 mclk = ~mclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_byte(input logic a, input logic [7:0] d);
        @(negedge mclk);
        hp_a = a;
        hp_data = d;
        repeat (2) @(negedge mclk);
        hp_wr_n = 1'h0;
        repeat (3) @(negedge mclk);
        hp_wr_n = 1'h1;
        repeat (6) @(negedge mclk);
    endtask : wr_byte
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr_byte(1'h1, a);
        wr_byte(1'h0, d);
    endtask : wr_reg
    task automatic count_on;
        c = 0;
        repeat (20)
        begin
            @(negedge mclk);
            c += int'(gate_upper[0]);
            s |= both_on;
        end
    endtask : count_on
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        conclude();
    end
    initial
    begin
        repeat (4) @(negedge mclk);
        rst = 1'h0;
        repeat (4) @(negedge mclk);
        chk(16'({gate_upper, gate_lower, gate_driver_shutdown_q, brake_out_q, fault_q,
            run_active_q}), 16'h03f4);
        $display("reset test done");
        foreach (ROWS[i])
        begin
            wr_reg(8'h0c, ROWS[i][11:4]);
            chk(16'({gate_driver_shutdown_q, brake_out_q, gate_upper[0], gate_lower[0]}),
                16'(ROWS[i][3:0]));
            repeat (6) @(negedge mclk);
            brake_request = 1'h1;
            repeat (3) @(negedge mclk);
            chk(16'(brake_out_q), 16'(!ROWS[i][2]));
            brake_request = 1'h0;
        end
        $display("polarity table done");
        gate_pol = 1'h1;
        wr_reg(8'h0c, 8'h30);
        // Period 9, dead 3 through auto-increment; scale per host formula
        wr_byte(1'h1, 8'h0d);
        wr_byte(1'h0, 8'h09);
        wr_byte(1'h0, 8'h10);
        wr_byte(1'h0, 8'h03);
        wr_reg(8'h44, 8'h1b);
        wr_reg(8'h17, 8'h03);
        chk(16'({run_active_q, direction_q}), 16'h0003);
        repeat (100) @(negedge mclk);
        for (int i = 0; i < 100 && pwm_sync_q !== 1'h0; i++) @(negedge mclk);
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (pwm_sync_q !== 1'h0 && n < 100);
        chk(16'(n), 16'h0014);
        chk(16'(gap), 16'h0003);
        foreach (MODES[i])
        begin
            wr_reg(8'h0e, MODES[i][23:16]);
            wr_reg(8'h51, MODES[i][15:8]);
            repeat (60) @(negedge mclk);
            count_on();
            chk(16'(c), 16'(MODES[i][7:0]));
        end
        chk(16'(s), 16'h0000);
        $display("carrier tests done");
        wr_reg(8'h17, 8'h02);
        chk(16'(direction_q), 16'h0000);
        wr_reg(8'h17, 8'h07);
        chk(16'({run_active_q, gate_upper, gate_lower}), 16'h0000);
        leg_shunt_select = 1'h1;
        wr_reg(8'h7d, 8'h01);
        wr_reg(8'h17, 8'h03);
        wr_reg(8'h17, 8'h01);
        chk(16'(run_active_q), 16'h0000);
        n = 0;
        repeat (60)
        begin
            @(negedge mclk);
            n += int'(offset_measure_start_q);
        end
        chk(16'(n), 16'h0001);
        $display("stop tests done");
        wr_reg(8'h17, 8'h03);
        trip = 1'h1;
        repeat (5) @(negedge mclk);
        chk(16'({fault_q, run_active_q, gate_upper}), 16'h0010);
        trip = 1'h0;
        wr_reg(8'h17, 8'h00);
        chk(16'(fault_q), 16'h0000);
        wr_reg(8'h0c, 8'hb0);
        repeat (5) @(negedge mclk);
        chk(16'(fault_q), 16'h0001);
        trip = 1'h1;
        wr_reg(8'h17, 8'h00);
        chk(16'(fault_q), 16'h0000);
        $display("fault tests done");
        chk(16'(iv_corrected_q), 16'h0002);
        wr_byte(1'h1, 8'h15);
        wr_byte(1'h0, 8'h00);
        wr_byte(1'h0, 8'h08);
        repeat (3) @(negedge mclk);
        chk(id_scaled_q, 16'h0246);
        chk(iq_scaled_q, 16'hffe0);
        wr_reg(8'h10, 8'hff);
        chk(id_scaled_q, 16'h0246);
        $display("feedback tests done");
        conclude();
    end
endmodule : svm_pwm_ctrl_tb_top
`default_nettype wire
